// [logic/ddc_consts.vh]
// Register offsets, field positions, reset values and codes for the datapath configuration bank.
`ifndef DDC_CONSTS_VH
`define DDC_CONSTS_VH
// ************************************************************
// Register byte addresses (printed index times four).
// ************************************************************
`define DDC_IDX_RUN        12'h100
`define DDC_IDX_CHAN       12'h101
`define DDC_IDX_FMT        12'h106
`define DDC_IDX_TERM       12'h107
`define DDC_IDX_DITH       12'h140
`define DDC_ADDR_RUN       14'h0400
`define DDC_ADDR_CHAN      14'h0404
`define DDC_ADDR_FMT       14'h0418
`define DDC_ADDR_TERM      14'h041C
`define DDC_ADDR_DITH      14'h0500
`define DDC_ADDR_STAT      14'h0600
// ************************************************************
// Reset values.
// ************************************************************
`define DDC_RST_RUN        8'h00
`define DDC_RST_CHAN       8'h02
`define DDC_RST_FMT        8'h00
`define DDC_RST_TERM       8'h01
`define DDC_RST_DITH       8'h00
// ************************************************************
// Field positions.
// ************************************************************
`define DDC_RUN_BIT        0
`define DDC_CHB_HI         7
`define DDC_CHB_LO         6
`define DDC_CHA_HI         5
`define DDC_CHA_LO         4
`define DDC_BANK_HI        1
`define DDC_BANK_LO        0
`define DDC_RES_HI         6
`define DDC_RES_LO         4
`define DDC_LSBSYNC_BIT    0
`define DDC_TERM_BIT       0
`define DDC_DITB_HI        3
`define DDC_DITB_LO        2
`define DDC_DITA_HI        1
`define DDC_DITA_LO        0
// ************************************************************
// Source codes.
// ************************************************************
`define DDC_SRC_OFF        2'h0
`define DDC_SRC_LVDS       2'h1
`define DDC_SRC_OSC        2'h2
`define DDC_SRC_CONST      2'h3
`endif

// [logic/ddc_sync3.v]
// Three-flop input synchroniser with agreement check.
`timescale 1ns/100ps
`default_nettype none
module ddc_sync3 (
  // Clock and reset.
  input  wire clk,
  input  wire nrst,
  // Data.
  input  wire din,
  output reg  dout_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Stages reset to the idle high level of the pin, so no false sync follows reset.
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      dout_q <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// [logic/ddc_dither.v]
// Per-channel dither span decoder.
`timescale 1ns/100ps
`default_nettype none
module ddc_dither (
  // Clock and reset.
  input  wire       clk,
  input  wire       nrst,
  // Level in.
  input  wire [1:0] level,
  // Span out, as signed LSB bounds.
  output reg  [3:0] span_hi_q,
  output reg  [3:0] span_lo_q
);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      span_hi_q <= 4'h0;
      span_lo_q <= 4'h0;
    end else begin
      case (level)
        2'h0: begin
          span_hi_q <= 4'h0;
          span_lo_q <= 4'h0;
        end
        2'h1: begin
          span_hi_q <= 4'h1;
          span_lo_q <= 4'hE;
        end
        2'h2: begin
          span_hi_q <= 4'h3;
          span_lo_q <= 4'hC;
        end
        default: begin
          span_hi_q <= 4'h7;
          span_lo_q <= 4'h8;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [logic/ddc_regs.v]
// APB register bank for the converter datapath configuration.
// How it works
// R1: Run bit one lets the datapath work and zero holds it in reset.
// R2: Software raises the run bit only with fuse load complete and the oscillator stopped.
// R3: Software sets the run bit only after all other configuration is done.
// R4: Software changes the channel configuration only while the run bit is zero.
// R5: Channel B source code 0 powers it down, 1 LVDS, 2 oscillator, 3 register constant.
// R6: Channel A source uses the same coding as channel B.
// R7: Bank count selects 1, 2 or 4 banks, 3 reserved, and with dual clock mode sets max rate; max_rate_sel_q follows dual_clock_mode_on alone.
// R8: Software avoids transmitting with bank count 2 and dual clock mode on.
// R9: Width field 0 to 3 gives 12 to 9 bits and anything higher gives 8 bits.
// R10: Low-bit-as-sync takes sync from the data LSB and ignores the sync pin.
// R11: Termination bit connects 100 Ohm across each LVDS pair.
// R12: Software writes dither only while the affected transmit enables are low.
// R13: Dither field 0 none, 1 +1/-2, 2 +3/-4, 3 +7/-8 LSB.
// R14: Datapath reset releases on the cycle after the run bit is written to one.
`timescale 1ns/100ps
`default_nettype none
`include "ddc_consts.vh"
module ddc_regs (
  // Clock and reset.
  input  wire        clk,
  input  wire        nrst,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Device status.
  input  wire        fuse_load_complete,
  input  wire        oscillator_run,
  input  wire        dual_clock_mode_on,
  input  wire        transmit_on_a,
  input  wire        transmit_on_b,
  // LVDS sync.
  input  wire        sync_n,
  input  wire        lvds_data_lsb,
  // Datapath control.
  output reg         datapath_rst_n_q,
  output reg         chan_a_power_q,
  output reg         chan_b_power_q,
  output reg  [1:0]  chan_a_source_q,
  output reg  [1:0]  chan_b_source_q,
  output reg  [2:0]  bank_count_q,
  output reg         max_rate_sel_q,
  output reg  [3:0]  input_bits_q,
  output reg         sync_q,
  output reg         term_on_q,
  output wire [3:0]  chan_a_dither_hi,
  output wire [3:0]  chan_a_dither_lo,
  output wire [3:0]  chan_b_dither_hi,
  output wire [3:0]  chan_b_dither_lo
);
  // ************************************************************
  // Address decode.
  // ************************************************************
  function [2:0] dec;
    input [13:0] a;
    begin
      case (a)
        `DDC_ADDR_RUN:  dec = 3'h1;
        `DDC_ADDR_CHAN: dec = 3'h2;
        `DDC_ADDR_FMT:  dec = 3'h3;
        `DDC_ADDR_TERM: dec = 3'h4;
        `DDC_ADDR_DITH: dec = 3'h5;
        `DDC_ADDR_STAT: dec = 3'h6;
        default:        dec = 3'h0;
      endcase
    end
  endfunction

  reg  [7:0] run_q;
  reg  [7:0] chan_q;
  reg  [7:0] fmt_q;
  reg  [7:0] term_q;
  reg  [7:0] dith_q;
  wire [2:0] sel   = dec(paddr);
  wire       acc   = psel && penable;
  wire       wr    = acc && pwrite && pstrb[0];
  wire       sync_pin_n;

  assign pready  = 1'b1;
  assign pslverr = acc && (sel == 3'h0);

  // ************************************************************
  // Register writes.
  // ************************************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q  <= `DDC_RST_RUN;
      chan_q <= `DDC_RST_CHAN;
      fmt_q  <= `DDC_RST_FMT;
      term_q <= `DDC_RST_TERM;
      dith_q <= `DDC_RST_DITH;
    end else if (wr) begin
      case (sel)
        3'h1: run_q <= pwdata[7:0];
        3'h2: chan_q <= pwdata[7:0];
        3'h3: fmt_q <= pwdata[7:0];
        3'h4: term_q <= pwdata[7:0];
        3'h5: dith_q <= pwdata[7:0];
        default: run_q <= run_q;
      endcase
    end
  end

  // ************************************************************
  // Read data.
  // ************************************************************
  always @* begin
    case (sel)
      3'h1: prdata = {24'h000000, run_q};
      3'h2: prdata = {24'h000000, chan_q};
      3'h3: prdata = {24'h000000, fmt_q};
      3'h4: prdata = {24'h000000, term_q};
      3'h5: prdata = {24'h000000, dith_q};
      3'h6: prdata = {27'h0000000, sync_q, dual_clock_mode_on, oscillator_run,
                      fuse_load_complete, datapath_rst_n_q};
      default: prdata = 32'h00000000;
    endcase
  end

  // ************************************************************
  // Datapath control decode.
  // ************************************************************
  ddc_sync3 u_sync (
    .clk    (clk),
    .nrst   (nrst),
    .din    (sync_n),
    .dout_q (sync_pin_n)
  );

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      datapath_rst_n_q <= 1'b0;
      chan_a_power_q   <= 1'b0;
      chan_b_power_q   <= 1'b0;
      chan_a_source_q  <= `DDC_SRC_OFF;
      chan_b_source_q  <= `DDC_SRC_OFF;
      bank_count_q     <= 3'h4;
      max_rate_sel_q   <= 1'b0;
      input_bits_q     <= 4'hC;
      sync_q           <= 1'b0;
      term_on_q        <= 1'b1;
    end else begin
      datapath_rst_n_q <= run_q[`DDC_RUN_BIT]; // R1 R14
      chan_b_source_q  <= chan_q[`DDC_CHB_HI:`DDC_CHB_LO]; // R5
      chan_b_power_q   <= chan_q[`DDC_CHB_HI:`DDC_CHB_LO] != `DDC_SRC_OFF; // R5
      chan_a_source_q  <= chan_q[`DDC_CHA_HI:`DDC_CHA_LO]; // R6
      chan_a_power_q   <= chan_q[`DDC_CHA_HI:`DDC_CHA_LO] != `DDC_SRC_OFF; // R6
      case (chan_q[`DDC_BANK_HI:`DDC_BANK_LO]) // R7
        2'h0: bank_count_q <= 3'h1;
        2'h1: bank_count_q <= 3'h2;
        2'h2: bank_count_q <= 3'h4;
        default: bank_count_q <= 3'h0;
      endcase
      max_rate_sel_q <= dual_clock_mode_on; // R7
      case (fmt_q[`DDC_RES_HI:`DDC_RES_LO]) // R9
        3'h0: input_bits_q <= 4'hC;
        3'h1: input_bits_q <= 4'hB;
        3'h2: input_bits_q <= 4'hA;
        3'h3: input_bits_q <= 4'h9;
        default: input_bits_q <= 4'h8;
      endcase
      if (fmt_q[`DDC_LSBSYNC_BIT]) begin
        sync_q <= lvds_data_lsb; // R10
      end else begin
        sync_q <= !sync_pin_n;
      end
      term_on_q <= term_q[`DDC_TERM_BIT]; // R11
    end
  end

  // ************************************************************
  // Dither decode per channel.
  // ************************************************************
  ddc_dither u_dith_a (
    .clk       (clk),
    .nrst      (nrst),
    .level     (dith_q[`DDC_DITA_HI:`DDC_DITA_LO]), // R13
    .span_hi_q (chan_a_dither_hi),
    .span_lo_q (chan_a_dither_lo)
  );

  ddc_dither u_dith_b (
    .clk       (clk),
    .nrst      (nrst),
    .level     (dith_q[`DDC_DITB_HI:`DDC_DITB_LO]), // R13
    .span_hi_q (chan_b_dither_hi),
    .span_lo_q (chan_b_dither_lo)
  );

  wire unused_ok = &{1'b0, transmit_on_a, transmit_on_b, pwdata[31:8], pstrb[3:1]};
endmodule
`default_nettype wire

// [testbench/ddc_regs_monitor.sv]
// Checker watching the ports of the datapath configuration register bank.
`timescale 1ns/100ps
`default_nettype none
`include "ddc_consts.vh"
module ddc_regs_monitor (
  // Clock, reset and bus.
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  // Datapath control.
  input wire logic        datapath_rst_n_q,
  input wire logic [1:0]  chan_a_source_q,
  input wire logic [1:0]  chan_b_source_q,
  input wire logic        chan_b_power_q,
  input wire logic [2:0]  bank_count_q,
  input wire logic [3:0]  input_bits_q,
  input wire logic        term_on_q,
  input wire logic [3:0]  chan_a_dither_hi,
  input wire logic [3:0]  chan_a_dither_lo
);
  // ****
  // Write events and properties.
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  function automatic logic [3:0] f_hi(input logic [1:0] l);
    return (4'h1 << l) - 4'h1;
  endfunction
  sequence s_wr(logic [13:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence
  a_run_follow: assert property (
    s_wr(`DDC_ADDR_RUN) |=> ##1 datapath_rst_n_q == $past(pwdata[0], 2))
    else $error("datapath reset does not follow run bit");
  a_src_b: assert property (
    s_wr(`DDC_ADDR_CHAN) |=> ##1 chan_b_source_q == $past(pwdata[7:6], 2)
      && chan_b_power_q == ($past(pwdata[7:6], 2) != 2'h0))
    else $error("channel b source or power wrong");
  a_src_a: assert property (
    s_wr(`DDC_ADDR_CHAN) |=> ##1 chan_a_source_q == $past(pwdata[5:4], 2))
    else $error("channel a source wrong");
  a_bank_count: assert property (
    s_wr(`DDC_ADDR_CHAN) |=> ##1 bank_count_q == (($past(pwdata[1:0], 2) == 2'h3)
      ? 3'h0 : 3'h1 << $past(pwdata[1:0], 2)))
    else $error("bank count decode wrong");
  a_res_width: assert property (
    s_wr(`DDC_ADDR_FMT) |=> ##1 input_bits_q == (($past(pwdata[6:4], 2) > 3'h3)
      ? 4'h8 : 4'hC - $past(pwdata[6:4], 2)))
    else $error("input resolution wrong");
  a_term_sel: assert property (
    s_wr(`DDC_ADDR_TERM) |=> ##1 term_on_q == $past(pwdata[0], 2))
    else $error("termination wrong");
  a_dith_span: assert property (
    s_wr(`DDC_ADDR_DITH) |=> ##2 chan_a_dither_hi == f_hi($past(pwdata[1:0], 3))
      && chan_a_dither_lo == (($past(pwdata[1:0], 3) == 2'h0)
      ? 4'h0 : ~f_hi($past(pwdata[1:0], 3))))
    else $error("dither span wrong");
  a_bad_addr: assert property (
    psel && penable && !(paddr inside {`DDC_ADDR_RUN, `DDC_ADDR_CHAN, `DDC_ADDR_FMT,
      `DDC_ADDR_TERM, `DDC_ADDR_DITH, `DDC_ADDR_STAT}) |-> pslverr)
    else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// [testbench/ddc_regs_bench.sv]
// Self-checking bench of the datapath configuration register bank.
`timescale 1ns/100ps
`default_nettype none
`include "ddc_consts.vh"
module ddc_regs_bench;
  // ****
  // Stimulus, checks and scenarios.
  // ****
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic        fuse = 1'b0, osc = 1'b0, dcm = 1'b0, tx = 1'b0, sync_n = 1'b1, lsb = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  dt [4] = '{8'h00, 8'h1E, 8'h3C, 8'h78};
  wire         pready, pslverr, rst_n, pa, pb, mrate, sq, term;
  wire  [31:0] prdata;
  wire  [1:0]  sa, sb;
  wire  [2:0]  bank;
  wire  [3:0]  bits, ah, al, bh, bl;
  int          bad_count = 0, samples_checked = 0;
  ddc_regs u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fuse_load_complete(fuse), .oscillator_run(osc),
    .dual_clock_mode_on(dcm), .transmit_on_a(tx), .transmit_on_b(tx), .sync_n(sync_n),
    .lvds_data_lsb(lsb), .datapath_rst_n_q(rst_n), .chan_a_power_q(pa), .chan_b_power_q(pb),
    .chan_a_source_q(sa), .chan_b_source_q(sb), .bank_count_q(bank), .max_rate_sel_q(mrate),
    .input_bits_q(bits), .sync_q(sq), .term_on_q(term), .chan_a_dither_hi(ah),
    .chan_a_dither_lo(al), .chan_b_dither_hi(bh), .chan_b_dither_lo(bl));
  always #2.5 clk = ~clk;
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hF};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("[ERR] pready expected 1 seen %b", pready);
      bad_count++;
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rdc(input logic [13:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("readback", e, rd);
    chk("rd err", 1'b0, err);
  endtask
  task hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    hold(2);
    chk("reset outs", 32'h0099, {rst_n, sa, sb, pa, pb, bank, bits, term});
    chk("reset dith", 16'h0, {ah, al, bh, bl});
    @(posedge clk);
    nrst <= 1'b1;
    hold(1);
    chk("sync after reset", 1'b0, sq);
    rdc(`DDC_ADDR_RUN, 32'h00);
    rdc(`DDC_ADDR_CHAN, 32'h02);
    rdc(`DDC_ADDR_FMT, 32'h00);
    rdc(`DDC_ADDR_TERM, 32'h01);
    rdc(`DDC_ADDR_DITH, 32'h00);
  endtask
  task t_chan;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `DDC_ADDR_CHAN, (i << 6) | ((3 - i) << 4) | i);
      hold(1);
      chk("sources", {i[1:0], 2'(3 - i)}, {sb, sa});
      chk("power", {i != 0, i != 3}, {pb, pa});
      chk("bank", (i == 3) ? 0 : (1 << i), bank);
    end
  endtask
  task t_fmt;
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, `DDC_ADDR_FMT, r << 4);
      hold(1);
      chk("bits", (r > 3) ? 8 : 12 - r, bits);
    end
    apb(1'b1, `DDC_ADDR_FMT, 32'h1);
    {sync_n, lsb} <= 2'b01;
    hold(6);
    chk("sync lsb", 1'b1, sq);
    @(posedge clk);
    lsb <= 1'b0;
    hold(6);
    chk("sync pin ignored", 1'b0, sq);
    apb(1'b1, `DDC_ADDR_FMT, 32'h0);
    hold(6);
    chk("sync pin", 1'b1, sq);
    @(posedge clk);
    sync_n <= 1'b1;
    hold(6);
    chk("sync idle", 1'b0, sq);
  endtask
  task t_term;
    apb(1'b1, `DDC_ADDR_TERM, 32'hFF);
    rdc(`DDC_ADDR_TERM, 32'hFF);
    chk("term on", 1'b1, term);
    apb(1'b1, `DDC_ADDR_TERM, 32'hFE);
    hold(1);
    chk("term off", 1'b0, term);
  endtask
  task t_dith;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `DDC_ADDR_DITH, ((3 - i) << 2) | i);
      hold(2);
      chk("dither a", dt[i], {ah, al});
      chk("dither b", dt[3 - i], {bh, bl});
    end
  endtask
  task t_run;
    @(posedge clk);
    {fuse, osc, dcm} <= 3'b101;
    apb(1'b1, `DDC_ADDR_RUN, 32'h1);
    #1;
    chk("run early", 1'b0, rst_n);
    hold(1);
    chk("run", 2'b11, {rst_n, mrate});
    rdc(`DDC_ADDR_STAT, 32'h0B);
    apb(1'b1, `DDC_ADDR_RUN, 32'h0);
    hold(1);
    chk("run off", 1'b0, rst_n);
    apb(1'b0, 14'h0408, 32'h0);
    chk("bad addr data", 32'h0, rd);
    chk("bad addr err", 1'b1, err);
    apb(1'b1, 14'h0408, 32'hFF);
    chk("bad wr err", 1'b1, err);
  endtask
  initial begin
    t_reset;
    t_chan;
    t_fmt;
    t_term;
    t_dith;
    t_run;
    t_reset;
    stop_test;
  end
endmodule
bind ddc_regs ddc_regs_monitor u_mon (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
  .datapath_rst_n_q(datapath_rst_n_q), .chan_a_source_q(chan_a_source_q),
  .chan_b_source_q(chan_b_source_q), .chan_b_power_q(chan_b_power_q),
  .bank_count_q(bank_count_q), .input_bits_q(input_bits_q), .term_on_q(term_on_q),
  .chan_a_dither_hi(chan_a_dither_hi), .chan_a_dither_lo(chan_a_dither_lo));
`default_nettype wire
